// >>> logic/bta_pkg.sv
// bta_pkg: constants, field layouts and carrier types for the error analyzer test control block.
// assumes a single 200 MHz clock and an APB master with 32-bit data.
//
// Overview of operation
// - realign setting picks search+realign, realign only, or neither.
// - search method is error-rate based or fast clock-to-data phase based.
// - error-rate search accumulates ten to the n bits per delay, n 4..11.
// - error-rate search judges each delay against ten to minus n, n 3..10.
// - eye result gives width, or code 1, 2 or 3 for search faults.
// - display selector shows totalize, window or test rate and total.
// - measurement reset restarts totalize and window, test results untouched.
// - four sticky history flags, one clear command resets them all.
// - each history flag can be read on its own.
// - summary gives window rate, total rate, clock, lock, then history flags.
// - lock indication follows pattern synchronization, registered one mclk later.
// - discard hides previous results until the next run to stop change.
// - test length is hours 0..24, minutes 0..59, seconds; used in timed/repeat.
// - untimed test runs until stop command, manual stop or power loss.
// - timed test ends itself when length elapses, or earlier on stop.
// - repeat test restarts at each length end until stopped.
// - result source selects interval in progress or last completed one.
// - print uses current results while running, else previous with end summary.
// - report enable is end-of-test, on-error, both or neither.
// - squelch hides on-error reports after 10 bad seconds, lifts after five good.
// - test threshold is ten to minus v, v 2..16, marks over-limit seconds.
// - controller starts with run, stops with stop; stop cuts a timed test short.
package bta_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int TICK_S = 1;
    localparam int SEC_CYCLES = CLK_HZ * TICK_S;

    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_CMD = 12'h004;
    localparam logic [11:0] OFS_TLEN = 12'h008;
    localparam logic [11:0] OFS_STAT = 12'h00C;
    localparam logic [11:0] OFS_EYE = 12'h010;
    localparam logic [11:0] OFS_SUMM = 12'h014;
    localparam logic [11:0] OFS_DISP = 12'h018;
    localparam logic [11:0] OFS_RES = 12'h01C;
    localparam logic [11:0] OFS_TIME = 12'h020;

    localparam int CMD_MEAS_RST = 0;
    localparam int CMD_HIST_CLR = 1;
    localparam int CMD_DISCARD = 2;
    localparam int CMD_RUN = 3;
    localparam int CMD_STOP = 4;
    localparam int CMD_PRINT = 5;

    localparam logic [3:0] SAMPLE_MIN = 4'h4;
    localparam logic [3:0] SAMPLE_MAX = 4'hB;
    localparam logic [3:0] STHR_MIN = 4'h3;
    localparam logic [3:0] STHR_MAX = 4'hA;
    localparam logic [4:0] TTHR_MIN = 5'h02;
    localparam logic [4:0] TTHR_MAX = 5'h10;
    localparam logic [5:0] HOURS_MAX = 6'h18;
    localparam logic [5:0] MINS_MAX = 6'h3B;
    localparam logic [5:0] SECS_MAX = 6'h3B;

    localparam logic [31:0] EYE_ONE = 32'h0000_0001;
    localparam logic [31:0] EYE_NONE = 32'h0000_0002;
    localparam logic [31:0] EYE_NOT_RUN = 32'h0000_0003;

    localparam logic [3:0] SQ_ON_SECS = 4'hA;
    localparam logic [3:0] SQ_OFF_SECS = 4'h5;

    typedef enum logic [1:0] {RA_AUTO, RA_OFF, RA_DISAB} bta_realign_t;
    typedef enum logic [1:0] {DS_TOTAL, DS_WINDOW, DS_TEST} bta_disp_t;
    typedef enum logic [1:0] {TM_UNTIMED, TM_TIMED, TM_REPEAT} bta_tmode_t;
    typedef enum logic [1:0] {RP_EOT, RP_ON_ERROR, RP_BOTH, RP_NONE} bta_report_t;

    typedef struct packed {
        logic [4:0] test_thres;
        logic squelch_en;
        bta_report_t report;
        logic result_prev;
        bta_tmode_t tmode;
        bta_disp_t disp;
        logic [3:0] search_thr;
        logic [3:0] sample_exp;
        logic search_fast;
        bta_realign_t realign;
    } bta_cfg_t;

    localparam int CFG_W = $bits(bta_cfg_t);
    localparam bta_cfg_t CFG_RST = '{test_thres: 5'h06, squelch_en: 1'b0, report: RP_NONE,
        result_prev: 1'b0, tmode: TM_UNTIMED, disp: DS_TOTAL, search_thr: 4'h6,
        sample_exp: 4'h6, search_fast: 1'b0, realign: RA_AUTO};

    typedef struct packed {
        logic [5:0] hours;
        logic [5:0] mins;
        logic [5:0] secs;
    } bta_tlen_t;

    localparam int TLEN_W = $bits(bta_tlen_t);
    localparam bta_tlen_t TLEN_RST = '{hours: 6'h00, mins: 6'h00, secs: 6'h0A};

    typedef struct packed {
        logic sync;
        logic bits;
        logic phase;
        logic power;
    } bta_hist_t;

    typedef struct packed {
        logic [7:0] rate_exp;
        logic [23:0] err_total;
    } bta_meas_t;
endpackage : bta_pkg

// >>> logic/bta_sec_timer.sv
// bta_sec_timer: one-second tick and elapsed-seconds count of the test interval.
// assumes restart is a one-cycle pulse from the test sequencer.
`timescale 1ns/1ps
module bta_sec_timer
    import bta_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic restart,
    // results
    output logic tick,
    output logic [16:0] elapsed
);
    logic [31:0] pre;

    wire pre_wrap = (pre == 32'(SEC_CYC - 1));

    // a restart realigns the prescaler so every interval gets whole seconds
    always_ff @(posedge mclk) begin
        if (sys_rst || restart) begin
            pre <= '0;
            tick <= 1'b0;
            elapsed <= '0;
        end else begin
            pre <= pre_wrap ? '0 : pre + 32'h0000_0001;
            tick <= pre_wrap;
            if (pre_wrap) begin
                elapsed <= elapsed + 17'h0_0001;
            end
        end
    end
endmodule : bta_sec_timer

// >>> logic/bta_ctrl.sv
// bta_ctrl: APB-reached test control of the error analyzer.
// assumes measurement inputs are synchronous to mclk; sec_* inputs are valid at every tick.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module bta_ctrl
    import bta_pkg::*;
#(
    parameter int SEC_CYC = SEC_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analyzer status
    input wire logic sync_lock,
    input wire bta_hist_t hist_evt,
    input wire logic manual_stop,
    input wire logic [10:0] clk_freq_mhz,
    input wire bta_meas_t tot_meas,
    input wire bta_meas_t win_meas,
    input wire bta_meas_t test_meas,
    input wire logic sec_has_err,
    input wire logic [4:0] sec_rate_exp,
    // delay search engine
    input wire logic search_ran,
    input wire logic [1:0] eye_cross,
    input wire logic [23:0] eye_width_ps,
    output logic search_en,
    output logic realign_en,
    output logic search_fast,
    output logic [3:0] sample_exp,
    output logic [3:0] search_thr,
    // measurement and report control
    output logic meas_restart,
    output logic test_running,
    output logic interval_start,
    output logic eot_report,
    output logic on_error_report,
    output logic print_req,
    output logic print_current,
    output logic lock_led,
    output bta_hist_t hist_led,
    output bta_meas_t disp_meas
);
    typedef enum logic {TS_STOP, TS_RUN} bta_state_t;

    function automatic logic in_range4(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
        in_range4 = (v >= lo) && (v <= hi);
    endfunction : in_range4

    function automatic logic [16:0] tlen_secs(input bta_tlen_t t);
        tlen_secs = 17'(t.hours * 12'd3600) + 17'(t.mins * 6'd60) + 17'(t.secs);
    endfunction : tlen_secs

    bta_cfg_t cfg;
    bta_tlen_t tlen;
    bta_state_t state;
    bta_meas_t prev_meas;
    logic results_valid;
    logic squelched;
    logic [3:0] over_run;
    logic [3:0] under_run;
    logic [14:0] over_limit_seconds;
    logic timer_restart;
    logic tick;
    logic [16:0] elapsed;

    // apb decode: zero-wait slave, write lands on the access edge
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wr = access && pwrite && !pslverr;
    wire addr_ok = (paddr == OFS_CFG) || (paddr == OFS_CMD) || (paddr == OFS_TLEN) ||
        (paddr == OFS_STAT) || (paddr == OFS_EYE) || (paddr == OFS_SUMM) ||
        (paddr == OFS_DISP) || (paddr == OFS_RES) || (paddr == OFS_TIME);
    wire wr_cfg = wr && (paddr == OFS_CFG);
    wire wr_tlen = wr && (paddr == OFS_TLEN);
    wire [5:0] cmd = (wr && (paddr == OFS_CMD)) ? pwdata[5:0] : 6'h00;
    wire cmd_run = cmd[CMD_RUN];
    wire cmd_stop = cmd[CMD_STOP];

    // out-of-range setup values are refused as a whole so the config never holds an illegal mix
    wire bta_cfg_t cfg_in = bta_cfg_t'(pwdata[CFG_W-1:0]);
    wire cfg_legal = (cfg_in.realign != 2'h3) && (cfg_in.disp != 2'h3) && (cfg_in.tmode != 2'h3) &&
        in_range4(cfg_in.sample_exp, SAMPLE_MIN, SAMPLE_MAX) &&
        in_range4(cfg_in.search_thr, STHR_MIN, STHR_MAX) &&
        (cfg_in.test_thres >= TTHR_MIN) && (cfg_in.test_thres <= TTHR_MAX);
    wire bta_tlen_t tlen_in = bta_tlen_t'(pwdata[TLEN_W-1:0]);
    wire tlen_legal = (tlen_in.hours <= HOURS_MAX) && (tlen_in.mins <= MINS_MAX) &&
        (tlen_in.secs <= SECS_MAX);

    // test sequencing
    wire running = (state == TS_RUN);
    wire stop_evt = cmd_stop || manual_stop || hist_evt.power;
    // elapsed already counts the second that this tick closes
    wire len_due = tick && (cfg.tmode != TM_UNTIMED) && (elapsed >= tlen_secs(tlen));
    wire start_now = !running && cmd_run;
    wire end_now = running && (stop_evt || (len_due && (cfg.tmode == TM_TIMED)));
    wire repeat_now = running && !stop_evt && len_due && (cfg.tmode == TM_REPEAT);
    wire interval_done = end_now || repeat_now;
    wire eot_on = (cfg.report == RP_EOT) || (cfg.report == RP_BOTH);
    wire oe_on = (cfg.report == RP_ON_ERROR) || (cfg.report == RP_BOTH);
    wire over_sec = sec_has_err && (sec_rate_exp < cfg.test_thres);

    bta_state_t next_state;
    assign next_state = start_now ? TS_RUN : (end_now ? TS_STOP : state);
    // restarting the timer on the start edge keeps a stale tick out of the new interval
    assign timer_restart = start_now || repeat_now;

    // readable words
    wire [31:0] eye_word = !search_ran ? EYE_NOT_RUN : (eye_cross == 2'h0) ? EYE_NONE :
        (eye_cross == 2'h1) ? EYE_ONE : {8'h00, eye_width_ps};
    wire [31:0] stat_word = {21'h00_0000, squelched, results_valid, running, lock_led,
        hist_led.sync, hist_led.bits, hist_led.phase, hist_led.power, 3'h0};
    wire [31:0] summ_word = {win_meas.rate_exp, tot_meas.rate_exp, clk_freq_mhz, lock_led, hist_led};
    wire bta_meas_t res_word = cfg.result_prev ? (results_valid ? prev_meas : '0) : test_meas;
    wire bta_meas_t next_disp = (cfg.disp == DS_WINDOW) ? win_meas :
        (cfg.disp == DS_TEST) ? test_meas : tot_meas;
    wire [31:0] next_prdata =
        (paddr == OFS_CFG) ? {{(32 - CFG_W){1'b0}}, cfg} :
        (paddr == OFS_TLEN) ? {{(32 - TLEN_W){1'b0}}, tlen} :
        (paddr == OFS_STAT) ? stat_word :
        (paddr == OFS_EYE) ? eye_word :
        (paddr == OFS_SUMM) ? summ_word :
        (paddr == OFS_DISP) ? disp_meas :
        (paddr == OFS_RES) ? res_word :
        (paddr == OFS_TIME) ? {over_limit_seconds, elapsed} : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_ok;
            prdata <= (setup && !pwrite) ? next_prdata : prdata;
        end
    end

    // setup registers
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg <= CFG_RST;
            tlen <= TLEN_RST;
        end else begin
            if (wr_cfg && cfg_legal) begin
                cfg <= cfg_in;
            end
            if (wr_tlen && tlen_legal) begin
                tlen <= tlen_in;
            end
        end
    end

    // search engine steering
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            search_en <= 1'b0;
            realign_en <= 1'b0;
            search_fast <= 1'b0;
            sample_exp <= SAMPLE_MIN;
            search_thr <= STHR_MIN;
            disp_meas <= '0;
        end else begin
            search_en <= (cfg.realign == RA_AUTO);
            realign_en <= (cfg.realign != RA_DISAB);
            search_fast <= cfg.search_fast;
            sample_exp <= cfg.sample_exp;
            search_thr <= cfg.search_thr;
            disp_meas <= next_disp;
        end
    end

    // history, lock and measurement restart; a new event beats a clear in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hist_led <= '0;
            lock_led <= 1'b0;
            meas_restart <= 1'b0;
        end else begin
            hist_led <= (cmd[CMD_HIST_CLR] ? '0 : hist_led) | hist_evt;
            lock_led <= sync_lock;
            meas_restart <= cmd[CMD_MEAS_RST];
        end
    end

    // test interval sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= TS_STOP;
            interval_start <= 1'b0;
            test_running <= 1'b0;
            prev_meas <= '0;
            results_valid <= 1'b0;
            eot_report <= 1'b0;
            print_req <= 1'b0;
            print_current <= 1'b0;
        end else begin
            state <= next_state;
            interval_start <= start_now || repeat_now;
            test_running <= (next_state == TS_RUN);
            if (interval_done) begin
                prev_meas <= test_meas;
            end
            // only a run to stop change sets valid, even against a discard in the same cycle
            results_valid <= end_now ? 1'b1 : (cmd[CMD_DISCARD] ? 1'b0 : results_valid);
            eot_report <= (interval_done && eot_on) || (cmd[CMD_PRINT] && !running);
            print_req <= cmd[CMD_PRINT];
            if (cmd[CMD_PRINT]) begin
                print_current <= running;
            end
        end
    end

    // per-second threshold and squelch counting
    always_ff @(posedge mclk) begin
        if (sys_rst || start_now) begin
            over_run <= '0;
            under_run <= '0;
            squelched <= 1'b0;
            over_limit_seconds <= '0;
            on_error_report <= 1'b0;
        end else begin
            on_error_report <= tick && running && over_sec && oe_on &&
                !(cfg.squelch_en && squelched);
            if (tick && running) begin
                if (over_sec) begin
                    over_limit_seconds <= over_limit_seconds + 15'h0001;
                    under_run <= '0;
                    over_run <= (over_run == SQ_ON_SECS) ? over_run : over_run + 4'h1;
                    if (cfg.squelch_en && (over_run + 4'h1 >= SQ_ON_SECS)) begin
                        squelched <= 1'b1;
                    end
                end else begin
                    over_run <= '0;
                    under_run <= (under_run == SQ_OFF_SECS) ? under_run : under_run + 4'h1;
                    if (under_run + 4'h1 >= SQ_OFF_SECS) begin
                        squelched <= 1'b0;
                    end
                end
            end
            if (!cfg.squelch_en) begin
                squelched <= 1'b0;
            end
        end
    end

    // the test length counter shares its tick with the squelch logic
    bta_sec_timer #(
        .SEC_CYC(SEC_CYC)
    ) u_timer (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .restart(timer_restart),
        .tick(tick),
        .elapsed(elapsed)
    );

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_realign_map: assert property (search_en |-> realign_en)
        else $error("search enabled without realignment");
    chk_hist_sticky: assert property (hist_led.bits && !cmd[CMD_HIST_CLR] |=> hist_led.bits)
        else $error("history flag dropped without clear");
    chk_hist_clear: assert property (cmd[CMD_HIST_CLR] && hist_evt == '0 |=> hist_led == '0)
        else $error("history clear missed");
    chk_lock_follow: assert property (lock_led == $past(sync_lock))
        else $error("lock indication does not follow sync");
    chk_restart_pulse: assert property (cmd[CMD_MEAS_RST] |=> meas_restart ##1 !meas_restart)
        else $error("measurement restart not a single pulse");
    chk_discard_hide: assert property (cmd[CMD_DISCARD] && !end_now |=> !results_valid)
        else $error("discard left results visible");
    chk_stop_ends: assert property (running && cmd_stop |=> !test_running)
        else $error("stop did not end the test");
    chk_untimed_runs: assert property (running && cfg.tmode == TM_UNTIMED && !stop_evt |=> test_running)
        else $error("untimed test ended without a stop");
    chk_timed_ends: assert property (running && cfg.tmode == TM_TIMED && len_due |=> !test_running)
        else $error("timed test overran its length");
    chk_repeat_again: assert property (repeat_now |=> test_running && interval_start)
        else $error("repeat test did not restart");
    chk_squelch_gate: assert property (squelched && cfg.squelch_en |=> !on_error_report)
        else $error("on-error report passed while squelched");
    chk_disp_select: assert property (cfg.disp == DS_WINDOW && $stable(win_meas) [*2] |-> disp_meas == win_meas)
        else $error("display does not show window results");
endmodule : bta_ctrl

// >>> dv/bta_host.sv
// bta_host: apb master standing in for the remote controller.
// assumes the slave answers within 16 access cycles; hang flags a missing answer.
`timescale 1ns/1ps
module bta_host
    import bta_pkg::*;
(
    // clock
    input wire logic mclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // bench flag
    output logic hang
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        hang = 1'b0;
    end

    // request held until pready is seen high, released only after that edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        hang <= pready !== 1'b1;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : bta_host

// >>> dv/bta_ctrl_tb.sv
// bta_ctrl_tb: self-checking bench for bta_ctrl with a 20-cycle second.
// assumes bta_host speaks apb; analyzer-side inputs are driven here.
`timescale 1ns/1ps
module bta_ctrl_tb
    import bta_pkg::*;
();
    localparam int SC = 20;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, hang, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic sync_lock = 1'b0;
    logic manual_stop = 1'b0;
    logic sec_has_err = 1'b0;
    logic search_ran = 1'b0;
    logic [10:0] clk_freq_mhz = 11'h000;
    logic [4:0] sec_rate_exp = 5'h00;
    logic [1:0] eye_cross = 2'h0;
    logic [23:0] eye_width_ps = 24'h000000;
    bta_hist_t hist_evt = 4'h0;
    bta_meas_t tot_meas = 32'h0, win_meas = 32'h0, test_meas = 32'h0;
    logic search_en, realign_en, search_fast, meas_restart, test_running, interval_start;
    logic eot_report, on_error_report, print_req, print_current, lock_led;
    logic [3:0] sample_exp, search_thr;
    bta_hist_t hist_led;
    bta_meas_t disp_meas;
    bta_cfg_t mcfg, c;
    int error_cnt = 0;
    int cmp_count = 0;
    int n_eot = 0, n_err = 0, n_ist = 0, n_mr = 0, n_pr = 0;
    int smp[6] = '{4, 11, 12, 5, 3, 5};
    int thr[6] = '{10, 3, 5, 2, 11, 5};
    int tth[6] = '{2, 16, 6, 6, 6, 17};

    always #2.5 mclk = ~mclk;

    bta_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));

    bta_ctrl #(.SEC_CYC(SC)) DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync_lock(sync_lock), .hist_evt(hist_evt), .manual_stop(manual_stop),
        .clk_freq_mhz(clk_freq_mhz), .tot_meas(tot_meas), .win_meas(win_meas), .test_meas(test_meas),
        .sec_has_err(sec_has_err), .sec_rate_exp(sec_rate_exp), .search_ran(search_ran),
        .eye_cross(eye_cross), .eye_width_ps(eye_width_ps), .search_en(search_en),
        .realign_en(realign_en), .search_fast(search_fast), .sample_exp(sample_exp),
        .search_thr(search_thr), .meas_restart(meas_restart), .test_running(test_running),
        .interval_start(interval_start), .eot_report(eot_report), .on_error_report(on_error_report),
        .print_req(print_req), .print_current(print_current), .lock_led(lock_led),
        .hist_led(hist_led), .disp_meas(disp_meas));

    // pulse outputs are counted so scenarios compare totals, not single edges
    always @(posedge mclk) begin
        n_eot <= n_eot + int'(eot_report);
        n_err <= n_err + int'(on_error_report);
        n_ist <= n_ist + int'(interval_start);
        n_mr <= n_mr + int'(meas_restart);
        n_pr <= n_pr + int'(print_req);
        if (hang) begin
            error_cnt++;
            summarize();
        end
    end

    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdv, err);
    endtask : wr

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0000_0000, rdv, err);
        chk(nm, rdv, e);
    endtask : rdchk

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic cmd(input int b);
        wr(OFS_CMD, 32'h1 << b);
    endtask : cmd

    task automatic wait_run(input logic v, input int lim, output int n);
        n = 0;
        while (test_running !== v && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (test_running !== v) begin
            error_cnt++;
            summarize();
        end
    endtask : wait_run

    initial begin
        int n;
        int r;
        int e0;
        int hm;
        void'($urandom(84));
        mcfg = '{5'h06, 1'b0, RP_NONE, 1'b0, TM_UNTIMED, DS_TOTAL, 4'h6, 4'h6, 1'b0, RA_AUTO};
        cyc(20);
        sys_rst <= 1'b0;
        rdchk("cfg", OFS_CFG, 32'(mcfg));
        rdchk("tlen", OFS_TLEN, 32'h0000_000A);
        rdchk("cmd", OFS_CMD, 32'h0000_0000);
        rdchk("unmapped", 12'h024, 32'h0000_0000);
        chk("slverr", err, 32'h1);
        for (r = 0; r < 3; r++) begin
            mcfg.realign = bta_realign_t'(r);
            mcfg.search_fast = r[0];
            wr(OFS_CFG, 32'(mcfg));
            cyc(2);
            chk("search_en", search_en, r == 0);
            chk("realign_en", realign_en, r != 2);
            chk("search_fast", search_fast, r[0]);
        end
        // out-of-range fields must leave the whole word as it was
        for (r = 0; r < 6; r++) begin
            c = mcfg;
            c.sample_exp = 4'(smp[r]);
            c.search_thr = 4'(thr[r]);
            c.test_thres = 5'(tth[r]);
            wr(OFS_CFG, 32'(c));
            if (smp[r] inside {[4:11]} && thr[r] inside {[3:10]} && tth[r] inside {[2:16]}) mcfg = c;
            cyc(2);
            chk("sample_exp", sample_exp, mcfg.sample_exp);
            chk("search_thr", search_thr, mcfg.search_thr);
            rdchk("cfg", OFS_CFG, 32'(mcfg));
        end
        for (r = 0; r < 3; r++) begin
            tot_meas <= $urandom;
            win_meas <= $urandom;
            test_meas <= $urandom;
            mcfg.disp = bta_disp_t'(r);
            wr(OFS_CFG, 32'(mcfg));
            cyc(2);
            rdchk("disp", OFS_DISP, r == 0 ? tot_meas : r == 1 ? win_meas : test_meas);
        end
        eye_width_ps <= 24'h000450;
        for (r = 0; r < 4; r++) begin
            search_ran <= r != 0;
            eye_cross <= r == 0 ? 2'h2 : 2'(r - 1);
            cyc(2);
            rdchk("eye", OFS_EYE, r == 0 ? EYE_NOT_RUN : r == 1 ? EYE_NONE : r == 2 ? EYE_ONE : 32'h450);
        end
        hm = ($urandom & 14) | 1;
        sync_lock <= 1'b1;
        clk_freq_mhz <= 11'($urandom);
        hist_evt <= 4'(hm);
        cyc(1);
        hist_evt <= 4'h0;
        cyc(3);
        chk("hist_led", hist_led, hm);
        chk("lock", lock_led, 32'h1);
        rdchk("stat", OFS_STAT, {21'h0, 3'h0, 1'b1, 4'(hm), 3'h0});
        rdchk("summ", OFS_SUMM, {win_meas.rate_exp, tot_meas.rate_exp, clk_freq_mhz, 1'b1, 4'(hm)});
        cmd(CMD_HIST_CLR);
        sync_lock <= 1'b0;
        cyc(3);
        chk("hist_clr", hist_led, 32'h0);
        chk("unlock", lock_led, 32'h0);
        mcfg.tmode = TM_TIMED;
        mcfg.report = RP_EOT;
        mcfg.result_prev = 1'b1;
        mcfg.test_thres = 5'h06;
        wr(OFS_CFG, 32'(mcfg));
        wr(OFS_TLEN, 32'h0000_0003);
        wr(OFS_TLEN, 32'h0001_9003);
        rdchk("tlen", OFS_TLEN, 32'h0000_0003);
        e0 = n_eot;
        cmd(CMD_RUN);
        wait_run(1'b1, 4, n);
        wait_run(1'b0, 100, n);
        chk("timed_len", n >= 3 * SC && n <= 3 * SC + 4, 32'h1);
        cyc(2);
        chk("eot", n_eot - e0, 32'h1);
        n = n_mr;
        cmd(CMD_MEAS_RST);
        cyc(2);
        chk("restart", n_mr - n, 32'h1);
        e0 = test_meas;
        test_meas <= ~test_meas;
        rdchk("res", OFS_RES, e0);
        cmd(CMD_DISCARD);
        rdchk("res_gone", OFS_RES, 32'h0);
        e0 = n_eot;
        n = n_pr;
        cmd(CMD_PRINT);
        cyc(2);
        chk("print", n_pr - n, 32'h1);
        chk("eot_sum", n_eot - e0, 32'h1);
        mcfg.tmode = TM_REPEAT;
        wr(OFS_CFG, 32'(mcfg));
        wr(OFS_TLEN, 32'h0000_0002);
        n = n_ist;
        cmd(CMD_RUN);
        cyc(130);
        chk("repeat", n_ist - n >= 3, 32'h1);
        rdchk("res_hidden", OFS_RES, 32'h0);
        cmd(CMD_PRINT);
        cyc(2);
        chk("print_cur", print_current, 32'h1);
        cmd(CMD_STOP);
        wait_run(1'b0, 4, n);
        rdchk("res_back", OFS_RES, test_meas);
        mcfg.tmode = TM_UNTIMED;
        mcfg.report = RP_ON_ERROR;
        mcfg.squelch_en = 1'b1;
        mcfg.result_prev = 1'b0;
        wr(OFS_CFG, 32'(mcfg));
        test_meas <= $urandom;
        wr(OFS_TLEN, 32'h0000_0001);
        rdchk("res_cur", OFS_RES, test_meas);
        sec_rate_exp <= 5'h03;
        sec_has_err <= 1'b1;
        n = n_err;
        cmd(CMD_RUN);
        cyc(16 * SC);
        chk("onerr", n_err - n, 32'hA);
        chk("untimed", test_running, 32'h1);
        sec_has_err <= 1'b0;
        cyc(7 * SC);
        host.xfer(1'b0, OFS_STAT, 32'h0, rdv, err);
        chk("unsquelch", rdv[10], 32'h0);
        manual_stop <= 1'b1;
        cyc(1);
        manual_stop <= 1'b0;
        wait_run(1'b0, 4, n);
        cmd(CMD_RUN);
        wait_run(1'b1, 4, n);
        hist_evt <= 4'h1;
        cyc(1);
        hist_evt <= 4'h0;
        wait_run(1'b0, 4, n);
        cyc(2);
        chk("power", hist_led, 32'h1);
        summarize();
    end

    initial begin
        cyc(20000);
        error_cnt++;
        summarize();
    end
endmodule : bta_ctrl_tb
